// file: design/srws_pkg.sv
/*
 * Constants and types for the two-wire register write and startup block.
 * Assumes a 100 MHz core clock; shared by the core and the link receiver.
 */
package srws_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 10;                            // Core clock period
	localparam int RESET_TIME_NS = 150000;                        // Reset sequence length
	localparam int RESET_CYCLES  = RESET_TIME_NS / CLK_PERIOD_NS; // Reset length in cycles

	// ----------------------------------------
	// Bus address and register offsets
	// ----------------------------------------
	localparam logic [6:0] SLAVE_ADDR      = 7'h46; // Two-wire slave address
	localparam logic       DIR_WRITE       = 1'b0;  // Direction bit for writes
	localparam logic [6:0] MODE_CTRL_ADDR  = 7'h00; // mode_control_reg offset
	localparam logic [6:0] CAL_ADDR        = 7'h7A; // Calibration load offset
	localparam logic [6:0] PWR_STEP_ADDR   = 7'h10; // power_loop_step_reg offset
	localparam logic [6:0] MOD_STEP_ADDR   = 7'h11; // modulation_step_reg offset
	localparam logic [6:0] BIAS_STEP_ADDR  = 7'h12; // bias_step_reg offset
	localparam logic [6:0] SOFT_RST_ADDR   = 7'h7F; // Soft reset register offset
	localparam int         SOFT_RST_BIT    = 0;     // Soft reset bit position
	localparam logic       STEP_PAGE       = 1'b1;  // Page holding the step registers
	localparam logic       PAGE_DEFAULT    = 1'b1;  // Page after reset

	// ----------------------------------------
	// Mode control codes and calibration data
	// ----------------------------------------
	localparam logic [7:0] MODE_SETUP      = 8'h12;
	localparam logic [7:0] MODE_CAL        = 8'h34;
	localparam logic [7:0] MODE_PAGE1      = 8'h55;
	localparam logic [7:0] MODE_FAULT_CLR  = 8'h68;
	localparam logic [7:0] MODE_PAGE0      = 8'h81;
	localparam logic [7:0] CAL_STEP1       = 8'h01;
	localparam logic [7:0] CAL_STEP2       = 8'h03;

	// ----------------------------------------
	// State enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {PH_IDLE, PH_REG, PH_DATA} srws_phase_t;
	typedef enum logic {RS_BUSY, RS_RUN} srws_rst_t;

endpackage : srws_pkg

// file: design/srws_link_if.sv
/*
 * Carrier between the core and the link receiver.
 * Assumes the core drives link_rst and samples the byte after a settled toggle.
 */
interface srws_link_if;
	logic       link_rst;   // Async frame reset of the link side
	logic [7:0] byte_data;  // Last complete byte
	logic       byte_first; // Byte was the address byte
	logic       byte_tgl;   // Toggles once per byte

	modport link (input link_rst, output byte_data, output byte_first, output byte_tgl);
	modport core (output link_rst, input byte_data, input byte_first, input byte_tgl);
endinterface : srws_link_if

// file: design/srws_link.sv
/*
 * Link receiver clocked by the bus clock: shifts bytes, drives acknowledge.
 * Assumes link_rst is raised at every START and STOP and drops while clock is low.
 */
module srws_link
	import srws_pkg::*;
(
	// Link clock and data pin
	input  wire logic link_clk,
	input  wire logic sda_in,
	output logic      sda_out,
	output logic      sda_oe,
	// Core side
	srws_link_if.link lnk
);

	typedef struct packed {
		logic [6:0] shift;      // Bits gathered so far
		logic [3:0] cnt;        // Bit slot, 8 is the acknowledge slot
		logic       first;      // Next byte is the address byte
		logic       match;      // Address matched a write
		logic [7:0] byte_data;  // Completed byte
		logic       byte_first; // Completed byte was the address
		logic       tgl;        // Byte event toggle
	} srws_link_t;

	srws_link_t s;      // Registered state
	srws_link_t next_s; // Next state
	logic       ack;    // Acknowledge drive, changes on falling clock

	// ----------------------------------------
	// Bit and byte assembly
	// ----------------------------------------
	always_comb begin
		next_s = s;
		if (s.cnt == 4'h8) begin
			next_s.cnt = 4'h0; // Acknowledge slot over
		end else begin
			next_s.shift = {s.shift[5:0], sda_in};
			next_s.cnt   = s.cnt + 4'h1;
			if (s.cnt == 4'h7) begin
				next_s.byte_data  = {s.shift, sda_in};
				next_s.byte_first = s.first;
				next_s.tgl        = ~s.tgl;
				next_s.first      = 1'b0;
				if (s.first) begin
					// Address with write direction only
					next_s.match = ({s.shift, sda_in} == {SLAVE_ADDR, DIR_WRITE});
				end
			end
		end
	end

	// State register, cleared by every frame boundary
	always_ff @(posedge link_clk or posedge lnk.link_rst) begin
		if (lnk.link_rst) begin
			s <= '{first: 1'b1, default: '0};
		end else begin
			s <= next_s;
		end
	end

	// Acknowledge each byte of an addressed write
	always_ff @(negedge link_clk or posedge lnk.link_rst) begin
		if (lnk.link_rst) begin
			ack <= 1'b0;
		end else begin
			ack <= (s.cnt == 4'h8) && s.match;
		end
	end

	assign sda_out        = 1'b0;
	assign sda_oe         = ack;
	assign lnk.byte_data  = s.byte_data;
	assign lnk.byte_first = s.byte_first;
	assign lnk.byte_tgl   = s.tgl;

endmodule : srws_link

// file: design/srws_core.sv
/*
 * Register write protocol, page and setup control, calibration load and reset
 * sequencing of a two-wire slave. Assumes the bus clock pin clocks the link
 * receiver and that the master keeps standard two-wire timing.
 */
module srws_core
	import srws_pkg::*;
#(
	parameter int RESET_LEN = RESET_CYCLES // Reset sequence length in cycles
)
(
	// Clock and reset
	input  wire logic       ref_clk,
	input  wire logic       reset,
	// Two-wire bus
	input  wire logic       scl_pin,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	// Transmitter and clock recovery
	input  wire logic       tx_enable_req,
	input  wire logic       tx_cdr_enable_req,
	input  wire logic       rx_cdr_enable_req,
	output logic            laser_enable,
	output logic            tx_cdr_enable,
	output logic            rx_cdr_enable,
	// Fault and interrupt
	output logic            fault_out,
	output logic            fault_oe,
	output logic            interrupt_output_pin,
	// Status
	output logic            power_on_done_flag,
	output logic            supply_3v_flag,
	output logic            page_select,
	output logic            setup_armed,
	output logic            calibration_loaded,
	output logic [7:0]      mode_control_reg,
	output logic [7:0]      power_loop_step_reg,
	output logic [7:0]      modulation_step_reg,
	output logic [7:0]      bias_step_reg,
	// Register read port
	input  wire logic       rd_page,
	input  wire logic [6:0] rd_addr,
	output logic [7:0]      rd_data
);

	// ----------------------------------------
	// Parameter check
	// ----------------------------------------
	if (RESET_LEN < 1 || RESET_LEN > 65535) begin : g_bad_len
		$error("RESET_LEN must be 1 to 65535");
	end

	localparam logic [15:0] RST_LAST = 16'(RESET_LEN - 1); // Last busy cycle

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [2:0]            scl_sync;  // Bus clock synchroniser
		logic [2:0]            sda_sync;  // Bus data synchroniser
		logic [2:0]            tgl_sync;  // Byte toggle synchroniser
		logic                  scl_v;     // Settled bus clock level
		logic                  sda_v;     // Settled bus data level
		logic                  tgl_seen;  // Last toggle level handled
		logic                  frame_open;// Between START and STOP
		logic                  frame_rst; // Link side held in reset
		srws_phase_t           phase;     // Byte position in the frame
		logic                  addressed; // Frame is a write to us
		logic [6:0]            reg_ptr;   // Register address counter
		logic                  armed;     // Setup mode armed
		logic                  armed_now; // Armed within this frame
		logic                  cal_armed; // Calibration write unlocked
		logic                  cal_stage; // First calibration word seen
		logic                  cal_done;  // Calibration loaded
		logic                  page;      // Selected page
		logic [7:0]            mode;      // Last mode control code
		srws_rst_t             rst_state; // Reset sequencer
		logic [15:0]           rst_cnt;   // Reset cycle count
		logic                  fault;     // Fault latch
		logic [1:0][127:0][7:0] regs;     // Register pages
		logic [7:0]            rd_data;   // Read port data
	} srws_state_t;

	// Pin levels start at the idle-high bus state, so release shows no false edge
	localparam srws_state_t RESET_STATE = '{
		scl_sync:  3'h7,
		sda_sync:  3'h7,
		scl_v:     1'b1,
		sda_v:     1'b1,
		phase:     PH_IDLE,
		rst_state: RS_BUSY,
		frame_rst: 1'b1,
		fault:     1'b1,
		page:      PAGE_DEFAULT,
		default:   '0
	};

	srws_state_t s;      // Registered state
	srws_state_t next_s; // Next state

	srws_link_if lnk (); // Link carrier

	// ----------------------------------------
	// Link receiver on the bus clock
	// ----------------------------------------
	srws_link u_link (
		.link_clk (scl_pin),
		.sda_in   (sda_in),
		.sda_out  (sda_out),
		.sda_oe   (sda_oe),
		.lnk      (lnk.link)
	);

	assign lnk.link_rst = s.frame_rst;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		logic       start_ev; // START seen
		logic       stop_ev;  // STOP seen
		logic       byte_ev;  // New byte from the link
		logic [7:0] d;        // Received byte
		logic       run;      // Reset sequence finished
		start_ev = 1'b0;
		stop_ev  = 1'b0;
		byte_ev  = 1'b0;
		d        = lnk.byte_data;
		run      = (s.rst_state == RS_RUN);
		next_s   = s;

		// Pin and toggle synchronisers, value taken once stages 2 and 3 agree
		next_s.scl_sync = {s.scl_sync[1:0], scl_pin};
		next_s.sda_sync = {s.sda_sync[1:0], sda_in};
		next_s.tgl_sync = {s.tgl_sync[1:0], lnk.byte_tgl};
		if (s.scl_sync[1] == s.scl_sync[2]) begin
			next_s.scl_v = s.scl_sync[2];
		end
		if (s.sda_sync[1] == s.sda_sync[2]) begin
			next_s.sda_v = s.sda_sync[2];
		end

		// Frame boundaries: data changes while clock is high
		start_ev = s.scl_v && next_s.scl_v && s.sda_v && !next_s.sda_v;
		stop_ev  = s.scl_v && next_s.scl_v && !s.sda_v && next_s.sda_v;

		// Byte events, ignored while the link is held in reset
		if (s.frame_rst) begin
			next_s.tgl_seen = 1'b0;
		end else if (s.tgl_sync[1] == s.tgl_sync[2] && s.tgl_sync[2] != s.tgl_seen) begin
			next_s.tgl_seen = s.tgl_sync[2];
			byte_ev         = 1'b1;
		end

		if (start_ev || stop_ev) begin
			// End of an operation that followed arming drops setup mode
			if (s.addressed && !s.armed_now) begin
				next_s.armed = 1'b0;
			end
			next_s.addressed  = 1'b0;
			next_s.armed_now  = 1'b0;
			next_s.phase      = PH_IDLE;
			next_s.frame_rst  = 1'b1;
			next_s.frame_open = start_ev;
		end else if (s.frame_open && !next_s.scl_v) begin
			// Release the link while the bus clock is low
			next_s.frame_rst = 1'b0;
		end

		if (byte_ev) begin
			if (lnk.byte_first) begin
				// Address byte: a matching write opens the frame
				next_s.addressed = (d == {SLAVE_ADDR, DIR_WRITE});
				next_s.phase     = (d == {SLAVE_ADDR, DIR_WRITE}) ? PH_REG : PH_IDLE;
			end else begin
				case (s.phase)
					PH_REG: begin
						// Register address within the page
						next_s.reg_ptr = d[6:0];
						next_s.phase   = PH_DATA;
					end
					PH_DATA: begin
						// Counter wraps inside the page, page bit untouched
						next_s.reg_ptr = s.reg_ptr + 7'h01;
						if (!run) begin
							// Writes during the reset sequence are dropped
						end else if (s.reg_ptr == MODE_CTRL_ADDR) begin
							next_s.mode = d;
							case (d)
								MODE_SETUP: begin
									next_s.armed     = 1'b1;
									next_s.armed_now = 1'b1;
								end
								MODE_PAGE0: next_s.page = 1'b0;
								MODE_PAGE1: next_s.page = 1'b1;
								MODE_FAULT_CLR: next_s.fault = 1'b0;
								MODE_CAL: next_s.cal_armed = 1'b1;
								default: begin
								end
							endcase
						end else if (s.reg_ptr == PWR_STEP_ADDR || s.reg_ptr == MOD_STEP_ADDR
							|| s.reg_ptr == BIAS_STEP_ADDR) begin
							// Step registers need no arming
							next_s.regs[s.page][s.reg_ptr] = d;
						end else if (s.cal_armed && s.reg_ptr == CAL_ADDR) begin
							// Calibration load words, no setup needed
							next_s.regs[s.page][s.reg_ptr] = d;
							next_s.cal_armed               = 1'b0;
							if (d == CAL_STEP1) begin
								next_s.cal_stage = 1'b1;
							end else if (d == CAL_STEP2 && s.cal_stage) begin
								next_s.cal_done = 1'b1;
							end
						end else if (s.armed) begin
							// Ordinary write, only while setup is armed
							next_s.regs[s.page][s.reg_ptr] = d;
							if (s.reg_ptr == SOFT_RST_ADDR && d[SOFT_RST_BIT]) begin
								// Soft reset restarts the full sequence
								next_s.rst_state = RS_BUSY;
								next_s.rst_cnt   = 16'h0000;
								next_s.fault     = 1'b1;
							end
						end
					end
					default: begin
					end
				endcase
			end
		end

		// Reset sequence: hold every register at its default
		if (s.rst_state == RS_BUSY) begin
			next_s.regs      = '0;
			next_s.mode      = 8'h00;
			next_s.page      = PAGE_DEFAULT;
			next_s.armed     = 1'b0;
			next_s.armed_now = 1'b0;
			next_s.cal_armed = 1'b0;
			next_s.cal_stage = 1'b0;
			next_s.cal_done  = 1'b0;
			next_s.fault     = 1'b1;
			next_s.rst_cnt   = s.rst_cnt + 16'h0001;
			if (s.rst_cnt == RST_LAST) begin
				next_s.rst_state = RS_RUN;
			end
		end

		// Read port
		next_s.rd_data = s.regs[rd_page][rd_addr];
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge ref_clk) begin
		if (reset) begin
			s <= RESET_STATE;
		end else begin
			s <= next_s;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	// Laser off during reset and until faults are cleared
	assign laser_enable  = tx_enable_req && (s.rst_state == RS_RUN) && !s.fault;
	// Clock recovery units need the calibration load
	assign tx_cdr_enable = tx_cdr_enable_req && s.cal_done;
	assign rx_cdr_enable = rx_cdr_enable_req && s.cal_done;
	// Open drain fault: released (pulled high) while the latch is set
	assign fault_out            = 1'b0;
	assign fault_oe             = !s.fault;
	assign interrupt_output_pin = s.fault;
	assign power_on_done_flag   = (s.rst_state == RS_BUSY);
	assign supply_3v_flag       = (s.rst_state == RS_BUSY);
	assign page_select          = s.page;
	assign setup_armed          = s.armed;
	assign calibration_loaded   = s.cal_done;
	assign mode_control_reg     = s.mode;
	assign power_loop_step_reg  = s.regs[STEP_PAGE][PWR_STEP_ADDR];
	assign modulation_step_reg  = s.regs[STEP_PAGE][MOD_STEP_ADDR];
	assign bias_step_reg        = s.regs[STEP_PAGE][BIAS_STEP_ADDR];
	assign rd_data              = s.rd_data;

endmodule : srws_core

// file: verif/srws_monitor.sv
/*
 * Checker on the ports of the register write and startup core.
 * Assumes one ref_clk domain and bench bus clock phases of 60 ns.
 */
module srws_monitor
	import srws_pkg::*;
#(
	parameter int RESET_LEN = RESET_CYCLES // Reset sequence length in cycles
)
(
	// Clock, reset and bus
	input wire logic       ref_clk,
	input wire logic       reset,
	input wire logic       scl_pin,
	input wire logic       sda_oe,
	// Enables
	input wire logic       tx_enable_req,
	input wire logic       tx_cdr_enable_req,
	input wire logic       rx_cdr_enable_req,
	input wire logic       laser_enable,
	input wire logic       tx_cdr_enable,
	input wire logic       rx_cdr_enable,
	// Fault, flags and registers
	input wire logic       fault_out,
	input wire logic       fault_oe,
	input wire logic       interrupt_output_pin,
	input wire logic       power_on_done_flag,
	input wire logic       supply_3v_flag,
	input wire logic       page_select,
	input wire logic       setup_armed,
	input wire logic       calibration_loaded,
	input wire logic [7:0] mode_control_reg,
	input wire logic [7:0] bias_step_reg
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [31:0] busy_cnt; // Cycles the power flag has been high

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	// Length of the current reset sequence
	always_ff @(posedge ref_clk) begin
		if (reset || !power_on_done_flag) begin
			busy_cnt <= '0;
		end else begin
			busy_cnt <= busy_cnt + 32'd1;
		end
	end

	a_ack_clock_low: assert property ($changed(sda_oe) |-> !scl_pin)
		else $error("acknowledge moved while bus clock high");
	a_ack_whole_bit: assert property ($rose(sda_oe) |=> sda_oe [*8])
		else $error("acknowledge shorter than a bit");
	a_laser_gate: assert property (
		laser_enable |-> tx_enable_req && !interrupt_output_pin)
		else $error("laser on while blocked");
	a_por_signals: assert property (
		power_on_done_flag |-> supply_3v_flag && interrupt_output_pin && !fault_oe && !fault_out)
		else $error("reset event not shown on fault and interrupt");
	a_release_safe: assert property (
		$fell(reset) |-> power_on_done_flag && page_select && !laser_enable)
		else $error("wrong state at reset release");
	a_reset_max: assert property (power_on_done_flag |-> busy_cnt <= RESET_LEN + 3)
		else $error("reset sequence too long");
	a_reset_min: assert property ($fell(power_on_done_flag) |-> busy_cnt >= RESET_LEN - 3)
		else $error("reset sequence too short");
	a_cdr_gate: assert property (
		{tx_cdr_enable, rx_cdr_enable} ==
		({tx_cdr_enable_req, rx_cdr_enable_req} & {2{calibration_loaded}}))
		else $error("clock recovery enable ignores calibration");
	a_page_code: assert property (
		$fell(page_select) |-> ##[0:3] (mode_control_reg == MODE_PAGE0))
		else $error("page 0 without its code");
	a_setup_code: assert property (
		$rose(setup_armed) |-> ##[0:3] (mode_control_reg == MODE_SETUP))
		else $error("setup armed without its code");
	a_soft_defaults: assert property (
		$rose(power_on_done_flag) |-> ##[0:2] (page_select && !calibration_loaded &&
		!setup_armed && bias_step_reg == 8'h00))
		else $error("registers not back to defaults");

	c_setup: cover property ($rose(setup_armed));
	c_page0: cover property ($fell(page_select));
	c_cal: cover property ($rose(calibration_loaded));
	c_soft: cover property ($rose(power_on_done_flag));
endmodule : srws_monitor

bind srws_core srws_monitor #(.RESET_LEN(RESET_LEN)) mon_u (
	.ref_clk(ref_clk), .reset(reset), .scl_pin(scl_pin), .sda_oe(sda_oe),
	.tx_enable_req(tx_enable_req), .tx_cdr_enable_req(tx_cdr_enable_req),
	.rx_cdr_enable_req(rx_cdr_enable_req), .laser_enable(laser_enable),
	.tx_cdr_enable(tx_cdr_enable), .rx_cdr_enable(rx_cdr_enable),
	.fault_out(fault_out), .fault_oe(fault_oe),
	.interrupt_output_pin(interrupt_output_pin),
	.power_on_done_flag(power_on_done_flag), .supply_3v_flag(supply_3v_flag),
	.page_select(page_select), .setup_armed(setup_armed),
	.calibration_loaded(calibration_loaded), .mode_control_reg(mode_control_reg),
	.bias_step_reg(bias_step_reg)
);

// file: verif/srws_host.sv
/*
 * Host model: two-wire bus master writing frames to the core.
 * Assumes the bench resolves the open-drain data wire with a pull-up.
 */
module srws_host
(
	// Bus pins
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda_wire
);
	timeunit 1ns;
	timeprecision 100ps;

	logic tick; // Host timebase, 15 ns period

	// Timebase unrelated in phase to ref_clk; clock stands high between frames
	initial begin
		tick = 1'b0;
		scl = 1'b1;
		sda_low = 1'b0;
		#3.3;
		forever begin
			#7.5 tick = ~tick;
		end
	end

	// Waits a number of host ticks
	task automatic wt(input int n);
		repeat (n) @(posedge tick);
	endtask : wt

	// START, n bytes MSB first with acknowledge sampled, STOP
	task automatic frame(input logic [7:0] b [5], input int n, output logic [4:0] nack);
		logic [7:0] sh;
		nack = '0;
		sda_low = 1'b1;
		wt(6);
		scl = 1'b0;
		wt(4);
		for (int k = 0; k < n; k++) begin
			sh = b[k];
			for (int i = 0; i < 9; i++) begin
				wt(2);
				sda_low = (i < 8) && !sh[7]; // Ninth bit released
				sh = sh << 1;
				wt(2);
				scl = 1'b1;
				wt(2);
				if (i == 8) begin
					nack[k] = sda_wire;
				end
				wt(2);
				scl = 1'b0;
			end
		end
		wt(2);
		sda_low = 1'b1;
		wt(2);
		scl = 1'b1;
		wt(6);
		sda_low = 1'b0;
		wt(6);
	endtask : frame
endmodule : srws_host

// file: verif/srws_core_tb.sv
/*
 * Bench for the write and startup core: host frames and port checks.
 * Assumes the host model as bus master and the monitor bound to the core.
 */
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin err_count++; \
	$display("ERROR %s expected %h seen %h", nm, exp, got); end end

module srws_core_tb
	import srws_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	localparam int RL = 200; // Short reset sequence

	logic       ref_clk, reset, scl_pin, sda_in, sda_out, sda_oe, sda_low;
	logic       tx_enable_req, tx_cdr_enable_req, rx_cdr_enable_req;
	logic       laser_enable, tx_cdr_enable, rx_cdr_enable;
	logic       fault_out, fault_oe, interrupt_output_pin, page_select;
	logic       power_on_done_flag, supply_3v_flag, setup_armed, calibration_loaded;
	logic       rd_page;
	logic [6:0] rd_addr;
	logic [7:0] rd_data, mode_control_reg, power_loop_step_reg;
	logic [7:0] modulation_step_reg, bias_step_reg;
	int         err_count, checks, cyc;
	logic [14:0] cal [5] = '{{MODE_CTRL_ADDR, MODE_PAGE1}, {MODE_CTRL_ADDR, MODE_CAL},
		{CAL_ADDR, CAL_STEP1}, {MODE_CTRL_ADDR, MODE_CAL}, {CAL_ADDR, CAL_STEP2}};

	srws_core #(.RESET_LEN(RL)) dut_u (
		.ref_clk(ref_clk), .reset(reset), .scl_pin(scl_pin), .sda_in(sda_in),
		.sda_out(sda_out), .sda_oe(sda_oe), .tx_enable_req(tx_enable_req),
		.tx_cdr_enable_req(tx_cdr_enable_req),
		.rx_cdr_enable_req(rx_cdr_enable_req), .laser_enable(laser_enable),
		.tx_cdr_enable(tx_cdr_enable), .rx_cdr_enable(rx_cdr_enable),
		.fault_out(fault_out), .fault_oe(fault_oe),
		.interrupt_output_pin(interrupt_output_pin),
		.power_on_done_flag(power_on_done_flag), .supply_3v_flag(supply_3v_flag),
		.page_select(page_select), .setup_armed(setup_armed),
		.calibration_loaded(calibration_loaded), .mode_control_reg(mode_control_reg),
		.power_loop_step_reg(power_loop_step_reg),
		.modulation_step_reg(modulation_step_reg), .bias_step_reg(bias_step_reg),
		.rd_page(rd_page), .rd_addr(rd_addr), .rd_data(rd_data)
	);
	srws_host host_u (.scl(scl_pin), .sda_low(sda_low), .sda_wire(sda_in));
	// Pull-up unless a party pulls low
	assign sda_in = !(sda_low || (sda_oe && !sda_out));

	initial begin
		ref_clk = 1'b0;
		forever begin
			#5 ref_clk = ~ref_clk;
		end
	end

	// Cuts a hang short
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			final_report();
		end
	end

	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : final_report

	// One frame; every byte must see the expected acknowledge bit
	task automatic frame(input logic [7:0] a0, a, d0, d1, d2, input int n, input logic nk);
		logic [7:0] b [5];
		logic [4:0] nack;
		b = '{a0, a, d0, d1, d2};
		host_u.frame(b, n, nack);
		for (int k = 0; k < n; k++) `CHK("ack", nk, nack[k])
		repeat (10) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask : frame

	// Writes n data bytes from offset a
	task automatic wr(input logic [6:0] a, input logic [7:0] d0, d1, d2, input int n);
		frame({SLAVE_ADDR, DIR_WRITE}, {1'b0, a}, d0, d1, d2, n + 2, 1'b0);
	endtask : wr

	task automatic chk_rd(input logic p, input logic [6:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		rd_page <= p;
		rd_addr <= a;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		`CHK("rd_data", exp, rd_data)
	endtask : chk_rd

	// Polls both power flags until they drop
	task automatic wait_ready();
		int n;
		n = 0;
		while ({power_on_done_flag, supply_3v_flag} !== 2'b00 && n < 4 * RL) begin
			@(negedge ref_clk);
			n++;
		end
		`CHK("flags", 2'b00, {power_on_done_flag, supply_3v_flag})
	endtask : wait_ready

	initial begin
		reset = 1'b1;
		tx_enable_req = 1'b1;
		tx_cdr_enable_req = 1'b1;
		rx_cdr_enable_req = 1'b1;
		rd_page = 1'b1;
		rd_addr = 7'h00;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		@(negedge ref_clk);
		`CHK("intr", 1'b1, interrupt_output_pin)
		`CHK("fault_oe", 1'b0, fault_oe)
		`CHK("laser", 1'b0, laser_enable)
		`CHK("page", PAGE_DEFAULT, page_select)
		`CHK("sda_drive", 2'b00, {sda_oe, sda_out})
		wait_ready();
		wr(MODE_CTRL_ADDR, MODE_FAULT_CLR, 8'h00, 8'h00, 1);
		`CHK("laser", 1'b1, laser_enable)
		`CHK("cdr", 2'b00, {tx_cdr_enable, rx_cdr_enable})
		foreach (cal[i]) wr(cal[i][14:8], cal[i][7:0], 8'h00, 8'h00, 1);
		`CHK("cdr", 2'b11, {tx_cdr_enable, rx_cdr_enable})
		@(posedge ref_clk);
		rx_cdr_enable_req <= 1'b0;
		@(negedge ref_clk);
		`CHK("cdr", 2'b10, {tx_cdr_enable, rx_cdr_enable})
		@(posedge ref_clk);
		rx_cdr_enable_req <= 1'b1;
		$display("startup test done");
		wr(PWR_STEP_ADDR, 8'h5A, 8'h00, 8'h00, 1);
		wr(MOD_STEP_ADDR, 8'h5B, 8'h00, 8'h00, 1);
		wr(BIAS_STEP_ADDR, 8'h5C, 8'h00, 8'h00, 1);
		`CHK("steps", 24'h5A_5B5C, {power_loop_step_reg, modulation_step_reg, bias_step_reg})
		wr(7'h06, 8'h99, 8'h00, 8'h00, 1);
		chk_rd(1'b1, 7'h06, 8'h00);
		wr(MODE_CTRL_ADDR, MODE_SETUP, 8'h00, 8'h00, 1);
		`CHK("armed", 1'b1, setup_armed)
		wr(7'h06, 8'h11, 8'h22, 8'h33, 3);
		`CHK("armed", 1'b0, setup_armed)
		for (int i = 0; i < 3; i++) chk_rd(1'b1, 7'h06 + 7'(i), 8'h11 * 8'(i + 1));
		wr(7'h06, 8'h77, 8'h00, 8'h00, 1);
		chk_rd(1'b1, 7'h06, 8'h11);
		$display("write test done");
		wr(MODE_CTRL_ADDR, MODE_SETUP, 8'h00, 8'h00, 1);
		frame(8'h8E, 8'h06, 8'h55, 8'h00, 8'h00, 3, 1'b1);
		frame(8'h8D, 8'h06, 8'h55, 8'h00, 8'h00, 3, 1'b1);
		wr(7'h06, 8'h44, 8'h00, 8'h00, 1);
		chk_rd(1'b1, 7'h06, 8'h44);
		$display("address test done");
		wr(MODE_CTRL_ADDR, MODE_PAGE0, 8'h00, 8'h00, 1);
		`CHK("page", 1'b0, page_select)
		`CHK("mode", MODE_PAGE0, mode_control_reg)
		wr(MODE_CTRL_ADDR, MODE_SETUP, 8'h00, 8'h00, 1);
		wr(7'h7E, 8'hA1, 8'hA2, 8'h00, 3);
		`CHK("page", 1'b0, page_select)
		`CHK("mode", 8'h00, mode_control_reg)
		chk_rd(1'b0, 7'h7E, 8'hA1);
		chk_rd(1'b0, 7'h7F, 8'hA2);
		chk_rd(1'b1, 7'h7E, 8'h00);
		wr(MODE_CTRL_ADDR, MODE_PAGE1, 8'h00, 8'h00, 1);
		`CHK("page", 1'b1, page_select)
		$display("page test done");
		@(posedge ref_clk);
		tx_enable_req <= 1'b0;
		wr(MODE_CTRL_ADDR, MODE_SETUP, 8'h00, 8'h00, 1);
		`CHK("laser", 1'b0, laser_enable)
		wr(SOFT_RST_ADDR, 8'(1 << SOFT_RST_BIT), 8'h00, 8'h00, 1);
		`CHK("por_flag", 1'b1, power_on_done_flag)
		`CHK("defaults", 10'h200, {page_select, calibration_loaded, bias_step_reg})
		`CHK("cdr", 2'b00, {tx_cdr_enable, rx_cdr_enable})
		wait_ready();
		@(posedge ref_clk);
		tx_enable_req <= 1'b1;
		@(negedge ref_clk);
		`CHK("laser", 1'b0, laser_enable)
		wr(MODE_CTRL_ADDR, MODE_FAULT_CLR, 8'h00, 8'h00, 1);
		`CHK("laser", 1'b1, laser_enable)
		$display("soft reset test done");
		final_report();
	end
endmodule : srws_core_tb
